// ### inc/pgmux_pkg.sv
// Constants and carrier types for the port G low pin function selector.
package pgmux_pkg;

   // Register byte offsets.
   localparam logic [3:0] PGMUX_OFS_LOW = 4'h0;
   localparam logic [3:0] PGMUX_OFS_CK = 4'h4;
   localparam logic [3:0] PGMUX_OFS_PIN8 = 4'h8;
   localparam logic [3:0] PGMUX_OFS_PINS = 4'hC;

   // Reset values, reserved-as-one masks and writable masks.
   localparam logic [15:0] PGMUX_LOW_RST = 16'hAA80;
   localparam logic [15:0] PGMUX_LOW_RSV = 16'hAA80;
   localparam logic [15:0] PGMUX_LOW_WR = 16'h557F;
   localparam logic [15:0] PGMUX_CK_RST = 16'hFFFE;
   localparam logic [15:0] PGMUX_CK_RSV = 16'hFFFE;
   localparam logic [15:0] PGMUX_CK_WR = 16'h0001;
   localparam logic PGMUX_PIN8_RST = 1'b0;

   // Field positions.
   localparam int PGMUX_B_PIN7 = 14;
   localparam int PGMUX_B_PIN6 = 12;
   localparam int PGMUX_B_PIN5 = 10;
   localparam int PGMUX_B_PIN4 = 8;
   localparam int PGMUX_B_PIN3 = 6;
   localparam int PGMUX_B_PIN2 = 5;
   localparam int PGMUX_B_PIN1 = 4;
   localparam int PGMUX_B_P0 = 2;
   localparam int PGMUX_B_IO = 0;
   localparam int PGMUX_B_CKLOW = 0;

   // Field encodings.
   localparam logic [1:0] PGMUX_P0_GPIO = 2'h0;
   localparam logic [1:0] PGMUX_P0_ADC_TRIGGER_IN = 2'h1;
   localparam logic [1:0] PGMUX_P0_INTERRUPT_REQUEST_OUT = 2'h2;
   localparam logic [1:0] PGMUX_IO_HIGH = 2'h0;
   localparam logic [1:0] PGMUX_IO_INTERRUPT_CONTROLLER = 2'h1;

   // Bus answers.
   localparam logic [1:0] PGMUX_RESP_OKAY = 2'h0;
   localparam logic [1:0] PGMUX_RESP_SLVERR = 2'h2;

   // Drive from the serial channels toward the pins.
   typedef struct packed {
      logic tx2;
      logic tx1;
      logic tx0;
      logic serial1_clock_io;
      logic serial0_clock_io;
   } pgmux_sero_t;

   // Pin levels handed to the serial channels.
   typedef struct packed {
      logic rx2;
      logic rx1;
      logic rx0;
      logic serial1_clock_io;
      logic serial0_clock_io;
   } pgmux_seri_t;

endpackage : pgmux_pkg

// ### core/pgmux_top.sv
// Port G low pin function selector with clock pin control and AXI4-Lite registers.
// Operation
// - Pin 8 mode bit 0 gives general I/O, 1 gives serial 2 receive.
// - Low select reserved bits 15,13,11,9,7 read one; software writes one.
// - Bit 14 selects pin 7: general I/O or serial 2 transmit.
// - Bit 12 selects pin 6: general I/O or serial 1 receive.
// - Bit 10 selects pin 5: general I/O or serial 1 transmit.
// - Bit 8 selects pin 4: general I/O or serial 1 clock.
// - Bit 6 selects pin 3: general I/O or serial 0 receive.
// - Bit 5 selects pin 2: general I/O or serial 0 transmit.
// - Bit 4 selects pin 1: general I/O or serial 0 clock.
// - Bits 3:2 give pin 0: I/O, A/D trigger, interrupt out, reserved.
// - Bits 1:0: interrupt output held high, or driven low while an interrupt request is present.
// - Clock control resets on power-on and hardware standby, else keeps value.
// - Clock force-low bit 0 drives the internal clock, 1 holds pin low.
// - Clock control bits 15 to 1 read one; software writes one.
// - Select registers reset on power-on and hardware standby, held otherwise.
// - Direction bits apply in general I/O and serial clock modes only.
module pgmux_top
   import pgmux_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // Clock, reset and freeze
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Port pins 8 to 0
   input wire logic [8:0] pin_i,
   output logic [8:0] pin_o,
   output logic [8:0] pin_oe,
   // General I/O side
   input wire logic [8:0] gpio_out,
   input wire logic [8:0] port_g_direction,
   output logic [8:0] gpio_in,
   // Peripherals
   input wire pgmux_sero_t ser_drv,
   output pgmux_seri_t ser_rcv,
   output logic adc_trigger_in,
   input wire logic interrupt_controller_request,
   // Clock pin
   input wire logic internal_clock_in,
   output logic clock_pin_out
);

   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W must be at least 4");
   end

   // Returns {hit, index} for a byte address; only aligned words hit.
   function automatic logic [2:0] fn_decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] top;
      top = a >> 4;
      fn_decode = {(top == '0) && (a[1:0] == 2'h0), a[3:2]};
   endfunction : fn_decode

   // Byte-lane merge of a 16-bit register with a write.
   function automatic logic [15:0] fn_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input logic [15:0] wr);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}} & wr;
      fn_merge = (old & ~m) | (d[15:0] & m);
   endfunction : fn_merge

   // Whether pin k is handed to its peripheral.
   function automatic logic fn_periph(input logic [15:0] lo, input logic p8, input int k);
      case (k)
         8: fn_periph = p8;
         7: fn_periph = lo[PGMUX_B_PIN7];
         6: fn_periph = lo[PGMUX_B_PIN6];
         5: fn_periph = lo[PGMUX_B_PIN5];
         4: fn_periph = lo[PGMUX_B_PIN4];
         3: fn_periph = lo[PGMUX_B_PIN3];
         2: fn_periph = lo[PGMUX_B_PIN2];
         1: fn_periph = lo[PGMUX_B_PIN1];
         default: fn_periph = 1'b0;
      endcase
   endfunction : fn_periph

   typedef enum {PGMUX_WR_IDLE, PGMUX_WR_RESP} pgmux_wst_t;

   pgmux_wst_t wst_r;
   logic aw_full_r;
   logic w_full_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [15:0] low_r;
   logic [15:0] ck_r;
   logic pin8_r;
   logic [8:0] sync1_r;
   logic [8:0] sync2_r;
   logic [8:0] sync3_r;
   logic [8:0] pin_f_r;
   logic [8:0] sel;
   logic [8:0] nxt_o;
   logic [8:0] nxt_oe;
   logic [1:0] p0_mode;
   logic [1:0] io_mode;
   logic [2:0] wdec;
   logic [2:0] rdec;
   logic do_write;

   assign p0_mode = low_r[PGMUX_B_P0 +: 2];
   assign io_mode = low_r[PGMUX_B_IO +: 2];
   assign wdec = fn_decode(aw_addr_r);
   assign rdec = fn_decode(araddr);
   assign do_write = (wst_r == PGMUX_WR_IDLE) && aw_full_r && w_full_r;

   for (genvar k = 0; k < 9; k++) begin : g_sel
      assign sel[k] = fn_periph(low_r, pin8_r, k);
   end

   // Write channel: address and data are caught in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         awready <= 1'b1;
         aw_addr_r <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_full_r <= 1'b1;
            awready <= 1'b0;
            aw_addr_r <= awaddr;
         end else if (bvalid && bready) begin
            aw_full_r <= 1'b0;
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         wready <= 1'b1;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_full_r <= 1'b1;
            wready <= 1'b0;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end else if (bvalid && bready) begin
            w_full_r <= 1'b0;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_r <= PGMUX_WR_IDLE;
         bvalid <= 1'b0;
         bresp <= PGMUX_RESP_OKAY;
      end else if (ce) begin
         case (wst_r)
            PGMUX_WR_IDLE: begin
               if (do_write) begin
                  wst_r <= PGMUX_WR_RESP;
                  bvalid <= 1'b1;
                  bresp <= wdec[2] ? PGMUX_RESP_OKAY : PGMUX_RESP_SLVERR;
               end
            end
            PGMUX_WR_RESP: begin
               if (bready) begin
                  wst_r <= PGMUX_WR_IDLE;
                  bvalid <= 1'b0;
               end
            end
            default: wst_r <= PGMUX_WR_IDLE;
         endcase
      end
   end

   // Only writable bits are stored; reserved bits are forced to one on read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_r <= PGMUX_LOW_RST & PGMUX_LOW_WR;
      end else if (ce && do_write && wdec == {1'b1, PGMUX_OFS_LOW[3:2]}) begin
         low_r <= fn_merge(low_r, w_data_r, w_strb_r, PGMUX_LOW_WR);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ck_r <= PGMUX_CK_RST & PGMUX_CK_WR;
      end else if (ce && do_write && wdec == {1'b1, PGMUX_OFS_CK[3:2]}) begin
         ck_r <= fn_merge(ck_r, w_data_r, w_strb_r, PGMUX_CK_WR);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin8_r <= PGMUX_PIN8_RST;
      end else if (ce && do_write && wdec == {1'b1, PGMUX_OFS_PIN8[3:2]} && w_strb_r[0]) begin
         pin8_r <= w_data_r[0];
      end
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= PGMUX_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= rdec[2] ? PGMUX_RESP_OKAY : PGMUX_RESP_SLVERR;
            case (rdec[1:0])
               PGMUX_OFS_LOW[3:2]: rdata <= {16'h0000, low_r | PGMUX_LOW_RSV};
               PGMUX_OFS_CK[3:2]: rdata <= {16'h0000, ck_r | PGMUX_CK_RSV};
               PGMUX_OFS_PIN8[3:2]: rdata <= {31'h0000_0000, pin8_r};
               default: rdata <= {23'h00_0000, pin_f_r};
            endcase
            if (!rdec[2]) begin
               rdata <= 32'h0000_0000;
            end
         end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
         end
      end
   end

   // Pins come from outside; a level counts once the last two stages agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 9'h1FF;
         sync2_r <= 9'h1FF;
         sync3_r <= 9'h1FF;
         pin_f_r <= 9'h1FF;
      end else if (ce) begin
         sync1_r <= pin_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_f_r <= (pin_f_r & (sync2_r ^ sync3_r)) | (sync3_r & ~(sync2_r ^ sync3_r));
      end
   end

   // Pin drive selection; direction bits rule only general I/O and serial clocks.
   always_comb begin
      nxt_o = gpio_out;
      nxt_oe = port_g_direction;
      if (sel[8]) begin
         nxt_oe[8] = 1'b0;
      end
      if (sel[7]) begin
         nxt_o[7] = ser_drv.tx2;
         nxt_oe[7] = 1'b1;
      end
      if (sel[6]) begin
         nxt_oe[6] = 1'b0;
      end
      if (sel[5]) begin
         nxt_o[5] = ser_drv.tx1;
         nxt_oe[5] = 1'b1;
      end
      if (sel[4]) begin
         nxt_o[4] = ser_drv.serial1_clock_io;
      end
      if (sel[3]) begin
         nxt_oe[3] = 1'b0;
      end
      if (sel[2]) begin
         nxt_o[2] = ser_drv.tx0;
         nxt_oe[2] = 1'b1;
      end
      if (sel[1]) begin
         nxt_o[1] = ser_drv.serial0_clock_io;
      end
      case (p0_mode)
         PGMUX_P0_ADC_TRIGGER_IN: nxt_oe[0] = 1'b0;
         PGMUX_P0_INTERRUPT_REQUEST_OUT: begin
            nxt_oe[0] = 1'b1;
            nxt_o[0] = (io_mode == PGMUX_IO_INTERRUPT_CONTROLLER) ? ~interrupt_controller_request : 1'b1;
         end
         default: ;
      endcase
   end

   // Outputs are registered so the pins never glitch on a mode change.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_o <= 9'h000;
         pin_oe <= 9'h000;
         gpio_in <= 9'h1FF;
         ser_rcv <= '1;
         adc_trigger_in <= 1'b1;
      end else if (ce) begin
         pin_o <= nxt_o;
         pin_oe <= nxt_oe;
         gpio_in <= pin_f_r;
         ser_rcv.rx2 <= sel[8] ? pin_f_r[8] : 1'b1;
         ser_rcv.rx1 <= sel[6] ? pin_f_r[6] : 1'b1;
         ser_rcv.rx0 <= sel[3] ? pin_f_r[3] : 1'b1;
         ser_rcv.serial1_clock_io <= sel[4] ? pin_f_r[4] : 1'b1;
         ser_rcv.serial0_clock_io <= sel[1] ? pin_f_r[1] : 1'b1;
         adc_trigger_in <= (p0_mode == PGMUX_P0_ADC_TRIGGER_IN) ? pin_f_r[0] : 1'b1;
      end
   end

   // The clock pin is a registered copy, so it lags the internal clock by one cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_pin_out <= 1'b0;
      end else if (ce) begin
         clock_pin_out <= ck_r[PGMUX_B_CKLOW] ? 1'b0 : internal_clock_in;
      end
   end

   sequence s_p0_adc_trigger_in;
      ce && p0_mode == PGMUX_P0_ADC_TRIGGER_IN;
   endsequence

   sequence s_p0_irq_high;
      ce && p0_mode == PGMUX_P0_INTERRUPT_REQUEST_OUT && io_mode == PGMUX_IO_HIGH;
   endsequence

   property p_rx2;
      @(posedge aclk) disable iff (!aresetn)
      ce && pin8_r |=> !pin_oe[8] && ser_rcv.rx2 == $past(pin_f_r[8]);
   endproperty
   a_rx2: assert property (p_rx2) else $error("pin 8 receive routing wrong");

   property p_low_rsv;
      @(posedge aclk) disable iff (!aresetn)
      ce && arvalid && arready && araddr == ADDR_W'(PGMUX_OFS_LOW)
         |=> rvalid && (rdata[15:0] & PGMUX_LOW_RSV) == PGMUX_LOW_RSV;
   endproperty
   a_low_rsv: assert property (p_low_rsv) else $error("low select reserved bits not one");

   property p_tx2;
      @(posedge aclk) disable iff (!aresetn)
      ce && low_r[PGMUX_B_PIN7] |=> pin_oe[7] && pin_o[7] == $past(ser_drv.tx2);
   endproperty
   a_tx2: assert property (p_tx2) else $error("pin 7 transmit routing wrong");

   property p_gpio7;
      @(posedge aclk) disable iff (!aresetn)
      ce && !low_r[PGMUX_B_PIN7] |=> pin_o[7] == $past(gpio_out[7]) && pin_oe[7] == $past(port_g_direction[7]);
   endproperty
   a_gpio7: assert property (p_gpio7) else $error("pin 7 general I/O wrong");

   property p_tx1;
      @(posedge aclk) disable iff (!aresetn)
      ce && low_r[PGMUX_B_PIN5] |=> pin_oe[5] && pin_o[5] == $past(ser_drv.tx1);
   endproperty
   a_tx1: assert property (p_tx1) else $error("pin 5 transmit routing wrong");

   property p_serial1_clock_io;
      @(posedge aclk) disable iff (!aresetn)
      ce && low_r[PGMUX_B_PIN4] |=> pin_o[4] == $past(ser_drv.serial1_clock_io) && pin_oe[4] == $past(port_g_direction[4]);
   endproperty
   a_serial1_clock_io: assert property (p_serial1_clock_io) else $error("pin 4 serial clock wrong");

   property p_rx0;
      @(posedge aclk) disable iff (!aresetn)
      ce && low_r[PGMUX_B_PIN3] |=> !pin_oe[3] && ser_rcv.rx0 == $past(pin_f_r[3]);
   endproperty
   a_rx0: assert property (p_rx0) else $error("pin 3 receive routing wrong");

   property p_tx0;
      @(posedge aclk) disable iff (!aresetn)
      ce && low_r[PGMUX_B_PIN2] |=> pin_oe[2] && pin_o[2] == $past(ser_drv.tx0);
   endproperty
   a_tx0: assert property (p_tx0) else $error("pin 2 transmit routing wrong");

   property p_adc_trigger_in;
      @(posedge aclk) disable iff (!aresetn)
      s_p0_adc_trigger_in |=> !pin_oe[0] && adc_trigger_in == $past(pin_f_r[0]);
   endproperty
   a_adc_trigger_in: assert property (p_adc_trigger_in) else $error("pin 0 trigger routing wrong");

   property p_irq_high;
      @(posedge aclk) disable iff (!aresetn)
      s_p0_irq_high |=> pin_oe[0] && pin_o[0];
   endproperty
   a_irq_high: assert property (p_irq_high) else $error("interrupt output not held high");

   property p_ck_rst;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> ck_r == 16'h0000 && low_r == (PGMUX_LOW_RST & PGMUX_LOW_WR);
   endproperty
   a_ck_rst: assert property (p_ck_rst) else $error("register reset value wrong");

   property p_ck_low;
      @(posedge aclk) disable iff (!aresetn)
      ce && ck_r[PGMUX_B_CKLOW] |=> !clock_pin_out;
   endproperty
   a_ck_low: assert property (p_ck_low) else $error("clock pin not held low");

   property p_p0_rsv;
      @(posedge aclk) disable iff (!aresetn)
      ce && p0_mode == 2'h3 |=> pin_oe[0] == $past(port_g_direction[0]) && adc_trigger_in;
   endproperty
   a_p0_rsv: assert property (p_p0_rsv) else $error("reserved pin 0 mode not general I/O");

endmodule : pgmux_top

// ### verification/pgmux_far_model.sv
// Far-side model: serial channels, interrupt controller, clock source and external pin drivers.
module pgmux_far_model
   import pgmux_pkg::*;
(
   // Clock and draw request
   input wire logic aclk,
   input wire logic draw,
   // Pins
   input wire logic [8:0] pin_o,
   input wire logic [8:0] pin_oe,
   output logic [8:0] pin_i,
   output logic [8:0] ext_lvl,
   // Peripherals
   output pgmux_sero_t ser_drv,
   output logic interrupt_controller_request,
   output logic internal_clock_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] st;

   initial begin
      st = 32'h00001D2B;
      ext_lvl = 9'h155;
      ser_drv = '0;
      interrupt_controller_request = 1'b0;
      internal_clock_in = 1'b0;
   end

   // The clock source runs free; peripheral drive and external levels change only on a draw.
   always @(posedge aclk) begin
      internal_clock_in <= ~internal_clock_in;
      if (draw) begin
         st = st ^ (st << 13);
         st = st ^ (st >> 17);
         st = st ^ (st << 5);
         ext_lvl <= st[8:0];
         ser_drv <= st[13:9];
         interrupt_controller_request <= st[14];
      end
   end

   // An external driver is always present, so a pin released by the device never floats.
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule : pgmux_far_model

// ### verification/port_g_low_pin_function_and_clock_out_test.sv
// Self-checking bench for the port G low pin selector and clock pin control.
module port_g_low_pin_function_and_clock_out_test
   import pgmux_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0;
   logic aresetn, ce, awvalid, wvalid, bready, arvalid, rready, draw;
   logic awready, wready, bvalid, arready, rvalid, interrupt_controller, ick, clock_pin_out, adc_trig, pc;
   logic [3:0] awaddr, araddr, wstrb;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, v;
   logic [31:0] rng = 32'h0000040F;
   logic [1:0] bresp, rresp;
   logic [8:0] pin_i, pin_o, pin_oe, gout, dir, gpio_in, ext, ew;
   logic [15:0] low;
   pgmux_sero_t sdrv;
   pgmux_seri_t srcv;
   int n_errors = 0;
   int cmp_count = 0;

   always #12.5 aclk = ~aclk;

   pgmux_top pgmux_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(awprot),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe(pin_oe), .gpio_out(gout), .port_g_direction(dir), .gpio_in(gpio_in),
      .ser_drv(sdrv), .ser_rcv(srcv), .adc_trigger_in(adc_trig), .interrupt_controller_request(interrupt_controller),
      .internal_clock_in(ick), .clock_pin_out(clock_pin_out));

   pgmux_far_model pgmux_far_model_inst (.aclk(aclk), .draw(draw), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_i(pin_i), .ext_lvl(ext), .ser_drv(sdrv), .interrupt_controller_request(interrupt_controller), .internal_clock_in(ick));

   function logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs

   task test_done;
      $display("Mismatches: %0d, comparisons: %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done

   task check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // Address and data are offered together; each is dropped on its own handshake.
   task wrc(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw_done, w_done;
      int t;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      t = 0;
      while (!(aw_done && w_done) && t < 100) begin
         @(posedge aclk);
         t++;
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
         t++;
      end while (bvalid !== 1'b1 && t < 200);
      bready <= 1'b0;
      check({34'h0, bresp}, {34'h0, er}, "write response");
   endtask : wrc

   task rdc(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      int t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
      end while (arready !== 1'b1 && t < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         t++;
      end while (rvalid !== 1'b1 && t < 200);
      rready <= 1'b0;
      check({2'h0, rresp, rdata}, {2'h0, er, ed}, "read answer");
   endtask : rdc

   // Works out the pin drive and the levels handed inward from the mode fields.
   task chk_pins(input logic [15:0] lo, input logic m8);
      logic [8:0] eoe, eo;
      eoe = dir;
      eo = gout;
      if (m8) eoe[8] = 1'b0;
      if (lo[14]) {eoe[7], eo[7]} = {1'b1, sdrv.tx2};
      if (lo[12]) eoe[6] = 1'b0;
      if (lo[10]) {eoe[5], eo[5]} = {1'b1, sdrv.tx1};
      if (lo[8]) eo[4] = sdrv.serial1_clock_io;
      if (lo[6]) eoe[3] = 1'b0;
      if (lo[5]) {eoe[2], eo[2]} = {1'b1, sdrv.tx0};
      if (lo[4]) eo[1] = sdrv.serial0_clock_io;
      if (lo[3:2] == PGMUX_P0_ADC_TRIGGER_IN) eoe[0] = 1'b0;
      if (lo[3:2] == PGMUX_P0_INTERRUPT_REQUEST_OUT) {eoe[0], eo[0]} = {1'b1, (lo[1:0] == PGMUX_IO_INTERRUPT_CONTROLLER) ? ~interrupt_controller : 1'b1};
      ew = (eoe & eo) | (~eoe & ext);
      check({27'h0, pin_oe}, {27'h0, eoe}, "pin enable");
      check({27'h0, pin_o & eoe}, {27'h0, eo & eoe}, "pin drive");
      check({27'h0, gpio_in}, {27'h0, ew}, "pin levels");
      check({31'h0, srcv}, {31'h0, m8 ? ew[8] : 1'b1, lo[12] ? ew[6] : 1'b1, lo[6] ? ew[3] : 1'b1,
         lo[8] ? ew[4] : 1'b1, lo[4] ? ew[1] : 1'b1}, "serial inputs");
      check({35'h0, adc_trig}, {35'h0, lo[3:2] == PGMUX_P0_ADC_TRIGGER_IN ? ew[0] : 1'b1}, "trigger");
   endtask : chk_pins

   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      test_done;
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, draw, awprot, arprot} = '0;
      {awaddr, araddr, wstrb, wdata, gout, dir} = '0;
      ce = 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(4'h0, 32'h0000AA80, PGMUX_RESP_OKAY);
      rdc(4'h4, 32'h0000FFFE, PGMUX_RESP_OKAY);
      rdc(4'h8, 32'h0, PGMUX_RESP_OKAY);
      chk_pins(16'hAA80, 1'b0);
      wrc(4'h0, 32'h0, 4'hF, PGMUX_RESP_OKAY);
      rdc(4'h0, 32'h0000AA80, PGMUX_RESP_OKAY);
      wrc(4'h4, 32'h0, 4'hF, PGMUX_RESP_OKAY);
      rdc(4'h4, 32'h0000FFFE, PGMUX_RESP_OKAY);
      wrc(4'h0, 32'h0000FFFF, 4'h2, PGMUX_RESP_OKAY);
      rdc(4'h0, 32'h0000FF80, PGMUX_RESP_OKAY);
      foreach (low[i]) begin
         if (i % 4 == 2) begin
            wrc(i[3:0], 32'h0, 4'hF, PGMUX_RESP_SLVERR);
            rdc(i[3:0], 32'h0, PGMUX_RESP_SLVERR);
         end
      end
      wrc(4'hC, 32'h0, 4'hF, PGMUX_RESP_OKAY);
      for (int i = 0; i < 32; i++) begin
         v = xs();
         // Reserved bits are always written as one; the first passes walk every pin 0 and output mode.
         low = v[15:0] | PGMUX_LOW_RSV;
         if (i < 16) low[3:0] = i[3:0];
         wrc(4'h0, {16'h0, low}, 4'hF, PGMUX_RESP_OKAY);
         wrc(4'h8, {31'h0, v[16]}, 4'h1, PGMUX_RESP_OKAY);
         dir <= v[25:17];
         gout <= xs() & 32'h000001FF;
         draw <= 1'b1;
         @(posedge aclk);
         draw <= 1'b0;
         repeat (10) @(posedge aclk);
         chk_pins(low, v[16]);
         rdc(4'h0, {16'h0, low}, PGMUX_RESP_OKAY);
         rdc(4'hC, {23'h0, ew}, PGMUX_RESP_OKAY);
      end
      wrc(4'h4, 32'h0000FFFF, 4'hF, PGMUX_RESP_OKAY);
      rdc(4'h4, 32'h0000FFFF, PGMUX_RESP_OKAY);
      repeat (8) begin
         @(negedge aclk);
         check({35'h0, clock_pin_out}, 36'h0, "clock pin low");
      end
      wrc(4'h4, 32'h0000FFFE, 4'hF, PGMUX_RESP_OKAY);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      pc = ick;
      repeat (8) begin
         @(negedge aclk);
         check({35'h0, clock_pin_out}, {35'h0, pc}, "clock pin follows");
         pc = ick;
      end
      // A second reset in mid-run must bring every register back to its initial value.
      wrc(4'h4, 32'h0000FFFF, 4'hF, PGMUX_RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(4'h0, 32'h0000AA80, PGMUX_RESP_OKAY);
      rdc(4'h4, 32'h0000FFFE, PGMUX_RESP_OKAY);
      rdc(4'h8, 32'h0, PGMUX_RESP_OKAY);
      test_done;
   end
endmodule : port_g_low_pin_function_and_clock_out_test
